// ===== design/ssf_serial_status_flags.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ssf_defs.svh"

module ssf_serial_status_flags (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic standby,
  input wire logic tx_load,
  input wire logic tx_last_bit,
  input wire logic rx_done,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity_bit,
  input wire logic rx_stop_bit,
  input wire logic rx_mp_bit,
  input wire logic dma_tx_write,
  input wire logic dma_rx_read,
  output logic [7:0] serial_status,
  output logic [7:0] serial_control,
  output logic [7:0] rx_buffer,
  output logic tx_multiproc_bit,
  output logic rx_hold,
  output logic tx_hold
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // set beats clear so an event in the clearing cycle survives
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set ? 1'b1 : (clr ? 1'b0 : cur);
  endfunction

  // arming: a fresh set disarms, a read that sees 1 arms, a clear disarms
  function automatic logic arm_next(input logic armed, input logic flag, input logic set,
                                    input logic rd, input logic clr);
    arm_next = (set | clr) ? 1'b0 : ((rd & flag) ? 1'b1 : armed);
  endfunction

  // true when ones in data plus parity bit break the chosen parity
  function automatic logic parity_bad(input logic [7:0] d, input logic p, input logic odd);
    parity_bad = ((^d) ^ p) != odd;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  logic wr_fire;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_fire;
  logic [31:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  ssf_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_fire(wr_fire),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_fire(rd_fire),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] armed_r;
  logic [7:0] armed_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] rxbuf_r;
  logic te_prev_r;
  logic rx_hold_r;
  logic tx_hold_r;

  // address decode, byte lane 0 carries every register
  wire wr_is_status = (wr_addr == `SSF_ADDR_STATUS);
  wire wr_is_ctrl = (wr_addr == `SSF_ADDR_CTRL);
  wire wr_is_rxbuf = (wr_addr == `SSF_ADDR_RXBUF);
  wire rd_is_status = (rd_addr == `SSF_ADDR_STATUS);
  wire rd_is_ctrl = (rd_addr == `SSF_ADDR_CTRL);
  wire rd_is_rxbuf = (rd_addr == `SSF_ADDR_RXBUF);
  wire status_wr = wr_fire & wr_is_status & wr_strb[0];
  wire ctrl_wr = wr_fire & wr_is_ctrl & wr_strb[0];
  wire status_rd = rd_fire & rd_is_status;

  // rx_buffer is read-only; a write there is accepted and dropped
  assign wr_err = ~(wr_is_status | wr_is_ctrl | wr_is_rxbuf);
  assign rd_err = ~(rd_is_status | rd_is_ctrl | rd_is_rxbuf);
  // upper data bits always read as zero
  assign rd_data = rd_is_status ? {24'h00_0000, status_r} :
                   rd_is_ctrl ? {24'h00_0000, ctrl_r} :
                   rd_is_rxbuf ? {24'h00_0000, rxbuf_r} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // control bits

  // two_stop is stored for the shifter only; the stop check needs nothing from it
  wire te = ctrl_r[`SSF_CTL_TRANSMIT_ENABLE];
  wire re = ctrl_r[`SSF_CTL_RECEIVE_ENABLE];
  wire sync_mode = ctrl_r[`SSF_CTL_SYNC_MODE];
  wire par_en = ctrl_r[`SSF_CTL_PARITY_ENABLE];
  wire par_odd = ctrl_r[`SSF_CTL_PARITY_ODD];
  wire mp_fmt = ctrl_r[`SSF_CTL_MULTIPROC];
  wire async_mode = ~sync_mode;
  // falling transmit enable, seen one cycle after the control write
  wire tx_disable = te_prev_r & ~te;

  ////////////////////////////////////////////////////////////////////////////
  // receive completion classification

  wire err_pending = status_r[`SSF_OVERRUN_ERROR] | status_r[`SSF_FRAMING_ERROR] |
                     status_r[`SSF_PARITY_ERROR];
  // completions are ignored while disabled or while errors wait
  wire rx_take = rx_done & re & ~err_pending;
  wire rx_buffer_full = status_r[`SSF_RX_BUFFER_FULL];
  wire rx_ovr = rx_take & rx_buffer_full;
  // an overrun keeps the old character, so only a free buffer is loaded
  wire rx_land = rx_take & ~rx_buffer_full;
  // only the first stop bit reaches this port; the second is never looked at
  wire rx_fer = rx_land & async_mode & ~rx_stop_bit;
  wire rx_per = rx_land & async_mode & par_en & parity_bad(rx_data, rx_parity_bit, par_odd);
  wire rx_ok = rx_land & ~rx_fer & ~rx_per;
  wire rx_mp_cap = rx_land & async_mode & mp_fmt;

  ////////////////////////////////////////////////////////////////////////////
  // flag set and clear terms

  wire tx_buffer_empty_set = tx_load | tx_disable;
  wire transmit_end_set = (tx_last_bit & status_r[`SSF_TX_BUFFER_EMPTY]) | tx_disable;
  // a zero write counts only where software saw the flag at 1
  wire [7:0] wr_zero = status_wr ? ~wr_data[7:0] : 8'h00;
  wire [7:0] sw_clr = wr_zero & armed_r;
  // a dma write is a hardware access and needs no read first
  wire tx_buffer_empty_clr = sw_clr[`SSF_TX_BUFFER_EMPTY] | dma_tx_write;

  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [7:0] rd_v;

  // per-bit set and clear vectors, bits 1 and 0 carry none
  always_comb begin
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[`SSF_TX_BUFFER_EMPTY] = tx_buffer_empty_set;
    clr_v[`SSF_TX_BUFFER_EMPTY] = tx_buffer_empty_clr;
    set_v[`SSF_RX_BUFFER_FULL] = rx_ok;
    clr_v[`SSF_RX_BUFFER_FULL] = sw_clr[`SSF_RX_BUFFER_FULL] | dma_rx_read;
    set_v[`SSF_OVERRUN_ERROR] = rx_ovr;
    clr_v[`SSF_OVERRUN_ERROR] = sw_clr[`SSF_OVERRUN_ERROR];
    set_v[`SSF_FRAMING_ERROR] = rx_fer;
    clr_v[`SSF_FRAMING_ERROR] = sw_clr[`SSF_FRAMING_ERROR];
    set_v[`SSF_PARITY_ERROR] = rx_per;
    clr_v[`SSF_PARITY_ERROR] = sw_clr[`SSF_PARITY_ERROR];
    // transmit end falls together with tx_buffer_empty
    set_v[`SSF_TRANSMIT_END] = transmit_end_set;
    clr_v[`SSF_TRANSMIT_END] = tx_buffer_empty_clr;
    rd_v = status_rd ? 8'hFF : 8'h00;
  end

  // next status: flags by set/clear, bit 1 by capture, bit 0 by software
  always_comb begin
    status_nxt = status_r;
    armed_nxt = 8'h00;
    for (int i = `SSF_TRANSMIT_END; i <= `SSF_TX_BUFFER_EMPTY; i++) begin
      status_nxt[i] = flag_next(status_r[i], set_v[i], clr_v[i]);
      armed_nxt[i] = arm_next(armed_r[i], status_r[i], set_v[i], rd_v[i], clr_v[i]);
    end
    // transmit end is never armed by software; it follows tx_buffer_empty
    armed_nxt[`SSF_TRANSMIT_END] = 1'b0;
    if (rx_mp_cap) begin
      status_nxt[`SSF_RX_MULTIPROC_BIT] = rx_mp_bit;
    end
    // bit 0 is a plain software bit with no read-before-write
    if (status_wr) begin
      status_nxt[`SSF_TX_MULTIPROC_BIT] = wr_data[`SSF_TX_MULTIPROC_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register, standby holds it at its reset value
  // standby wins over every event that falls in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      status_r <= `SSF_STATUS_RESET;
      armed_r <= 8'h00;
    end else begin
      status_r <= status_nxt;
      armed_r <= armed_nxt;
    end
  end

  // receive buffer: errored characters still land, overrun keeps old data
  // standby leaves the buffer alone; only reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxbuf_r <= 8'h00;
    end else if (rx_land) begin
      rxbuf_r <= rx_data;
    end
  end

  // control register; transmit enable history feeds the disable edge
  // the mask keeps bit 7 at zero so it always reads 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `SSF_CTL_RESET;
      te_prev_r <= 1'b0;
    end else begin
      te_prev_r <= te;
      if (ctrl_wr) begin
        ctrl_r <= wr_data[7:0] & `SSF_CTL_MASK;
      end
    end
  end

  // hold outputs stop the receive shifter while an error is pending, and the transmit shifter only in sync mode
  // they track the flags of the same edge, so a cleared error frees the shifters at once
  wire err_nxt = status_nxt[`SSF_OVERRUN_ERROR] | status_nxt[`SSF_FRAMING_ERROR] |
                 status_nxt[`SSF_PARITY_ERROR];
  wire sync_nxt = ctrl_wr ? wr_data[`SSF_CTL_SYNC_MODE] : sync_mode;
  // standby drops the holds together with the flags
  always_ff @(posedge aclk) begin
    if (!aresetn || standby) begin
      rx_hold_r <= 1'b0;
      tx_hold_r <= 1'b0;
    end else begin
      rx_hold_r <= err_nxt;
      tx_hold_r <= sync_nxt & err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops
  assign serial_status = status_r;
  assign serial_control = ctrl_r;
  assign rx_buffer = rxbuf_r;
  // only meaningful for asynchronous multiprocessor framing
  assign tx_multiproc_bit = status_r[`SSF_TX_MULTIPROC_BIT];
  assign rx_hold = rx_hold_r;
  assign tx_hold = tx_hold_r;

endmodule // ssf_serial_status_flags

// ===== design/ssf_defs.svh
`ifndef SSF_DEFS_SVH
`define SSF_DEFS_SVH

// register byte addresses on the AXI4-Lite port
`define SSF_ADDR_STATUS 32'h0000_0000
`define SSF_ADDR_CTRL 32'h0000_0004
`define SSF_ADDR_RXBUF 32'h0000_0008

// serial_status field positions
`define SSF_TX_BUFFER_EMPTY 7
`define SSF_RX_BUFFER_FULL 6
`define SSF_OVERRUN_ERROR 5
`define SSF_FRAMING_ERROR 4
`define SSF_PARITY_ERROR 3
`define SSF_TRANSMIT_END 2
`define SSF_RX_MULTIPROC_BIT 1
`define SSF_TX_MULTIPROC_BIT 0

// serial_status value after reset and in standby
`define SSF_STATUS_RESET 8'h84

// serial_control field positions (block-local control register)
`define SSF_CTL_TRANSMIT_ENABLE 0
`define SSF_CTL_RECEIVE_ENABLE 1
`define SSF_CTL_SYNC_MODE 2
`define SSF_CTL_PARITY_ENABLE 3
`define SSF_CTL_PARITY_ODD 4
`define SSF_CTL_TWO_STOP 5
`define SSF_CTL_MULTIPROC 6
`define SSF_CTL_RESET 8'h00
`define SSF_CTL_MASK 8'h7F

// axi responses
`define SSF_RESP_OKAY 2'h0
`define SSF_RESP_SLVERR 2'h2

`endif

// ===== design/ssf_pkg.sv
package ssf_pkg;

  // write channel progress of the bus slave, gray from collect to issue to resp; two bits flip on the return to collect
  typedef enum logic [1:0] {
    SSF_WR_COLLECT = 2'h0,
    SSF_WR_ISSUE = 2'h1,
    SSF_WR_RESP = 2'h3
  } ssf_wr_state_t;

  // read channel progress of the bus slave
  typedef enum logic {
    SSF_RD_IDLE = 1'h0,
    SSF_RD_RESP = 1'h1
  } ssf_rd_state_t;

endpackage

// ===== design/ssf_axil_slave.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"

module ssf_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_fire,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_fire,
  output logic [31:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  ssf_pkg::ssf_wr_state_t wst_r;
  ssf_pkg::ssf_rd_state_t rst_r;
  logic have_aw_r;
  logic have_w_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_take;
  logic w_take;

  // address and data may arrive in either order; each is held once taken
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = (wst_r == ssf_pkg::SSF_WR_ISSUE);
  assign wr_addr = awaddr_r;
  assign wr_data = wdata_r;
  assign wr_strb = wstrb_r;
  // read side effects happen on the address handshake itself
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;

  ////////////////////////////////////////////////////////////////////////////
  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= ssf_pkg::SSF_WR_COLLECT;
      have_aw_r <= 1'b0;
      have_w_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSF_RESP_OKAY;
    end else begin
      case (wst_r)
        ssf_pkg::SSF_WR_COLLECT: begin
          if (aw_take) begin
            awaddr_r <= s_axi_awaddr;
            have_aw_r <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (w_take) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            have_w_r <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if ((have_aw_r | aw_take) & (have_w_r | w_take)) begin
            wst_r <= ssf_pkg::SSF_WR_ISSUE;
          end
        end
        ssf_pkg::SSF_WR_ISSUE: begin
          s_axi_bresp <= wr_err ? `SSF_RESP_SLVERR : `SSF_RESP_OKAY;
          s_axi_bvalid <= 1'b1;
          wst_r <= ssf_pkg::SSF_WR_RESP;
        end
        ssf_pkg::SSF_WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wst_r <= ssf_pkg::SSF_WR_COLLECT;
          end
        end
        default: wst_r <= ssf_pkg::SSF_WR_COLLECT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read in flight, data registered on the handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r <= ssf_pkg::SSF_RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSF_RESP_OKAY;
    end else begin
      case (rst_r)
        ssf_pkg::SSF_RD_IDLE: begin
          if (rd_fire) begin
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `SSF_RESP_SLVERR : `SSF_RESP_OKAY;
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0;
            rst_r <= ssf_pkg::SSF_RD_RESP;
          end
        end
        ssf_pkg::SSF_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rst_r <= ssf_pkg::SSF_RD_IDLE;
          end
        end
        default: rst_r <= ssf_pkg::SSF_RD_IDLE;
      endcase
    end
  end

endmodule // ssf_axil_slave

// ===== bench/ssf_remote_end.sv
`timescale 1ns/1ps
module ssf_remote_end (
  input wire logic aclk,
  output logic rx_done,
  output logic [7:0] rx_data,
  output logic rx_parity_bit,
  output logic rx_stop_bit,
  output logic rx_mp_bit,
  output logic tx_last_bit
);
  ////////////////////////////////////////
  // idle line: no character, no last bit
  initial begin
    rx_done = 1'b0;
    tx_last_bit = 1'b0;
    {rx_data, rx_parity_bit, rx_stop_bit, rx_mp_bit} = 11'h5A5;
  end
  // one character from the remote transmitter; only the first stop bit reaches the block
  task automatic send(input logic [7:0] d, input logic p, input logic s, input logic m);
    {rx_data, rx_parity_bit, rx_mp_bit} <= {d, p, m};
    rx_stop_bit <= s;
    rx_done <= 1'b1;
    @(posedge aclk);
    rx_done <= 1'b0;
    // stale fields are inverted so they never look valid by chance
    {rx_data, rx_parity_bit, rx_stop_bit, rx_mp_bit} <= ~{d, p, s, m};
    @(posedge aclk);
  endtask
  // remote receiver has taken the last bit of a character
  task automatic last_bit();
    tx_last_bit <= 1'b1;
    @(posedge aclk);
    tx_last_bit <= 1'b0;
    @(posedge aclk);
  endtask
endmodule // ssf_remote_end

// ===== bench/ssf_serial_status_flags_asserts.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_status_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic standby,
  input wire logic tx_load,
  input wire logic tx_last_bit,
  input wire logic rx_done,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity_bit,
  input wire logic rx_stop_bit,
  input wire logic dma_tx_write,
  input wire logic dma_rx_read,
  input wire logic [7:0] serial_status,
  input wire logic [7:0] serial_control,
  input wire logic [7:0] rx_buffer,
  input wire logic rx_hold,
  input wire logic tx_hold
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // starting steps of bus answers and of a clean async reception
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rx_clean;
    rx_done && serial_control[1] && !serial_control[2] && serial_status[6:3] == 4'h0 && !standby;
  endsequence
  ////////////////////////////////////////
  // flag behaviour
  a_reset_value: assert property ($rose(aresetn) |-> serial_status == `SSF_STATUS_RESET)
    else $error("status not at reset value");
  a_standby_value: assert property (standby |=> serial_status == `SSF_STATUS_RESET)
    else $error("status not cleared by standby");
  a_load_sets: assert property (tx_load && !standby |=> serial_status[7])
    else $error("load did not set empty flag");
  a_last_bit_end: assert property (tx_last_bit && serial_status[7] && !dma_tx_write
    && !standby |=> serial_status[2])
    else $error("last bit did not set end flag");
  a_dma_write_clr: assert property (dma_tx_write && !tx_load && !tx_last_bit && !standby
    && !$fell(serial_control[0]) |=> !serial_status[7])
    else $error("dma write left empty flag set");
  a_dma_read_clr: assert property (dma_rx_read && !rx_done && !standby |=> !serial_status[6])
    else $error("dma read left full flag set");
  a_overrun_keeps: assert property (rx_done && serial_control[1] && serial_status[6:3] == 4'h8 && !dma_rx_read
    && !standby |=> serial_status[5] && $stable(rx_buffer))
    else $error("overrun not flagged or buffer changed");
  a_error_blocks: assert property (rx_done && (|serial_status[5:3]) && !dma_rx_read && !standby
    |=> $stable(rx_buffer) && $stable(serial_status[6]))
    else $error("reception went on with errors pending");
  a_framing_loads: assert property (s_rx_clean ##0 !rx_stop_bit
    |=> serial_status[4] && !serial_status[6] && rx_buffer == $past(rx_data))
    else $error("framing error handling wrong");
  a_parity_sets: assert property (s_rx_clean ##0 serial_control[3]
    && (^{rx_data, rx_parity_bit}) != serial_control[4] |=> serial_status[3] && !serial_status[6])
    else $error("parity error handling wrong");
  a_hold_on_err: assert property (rx_hold == (|serial_status[5:3]))
    else $error("receive hold does not follow error flags");
  a_tx_hold_sync: assert property (tx_hold == (rx_hold && serial_control[2]))
    else $error("transmit hold does not follow sync errors");
  ////////////////////////////////////////
  // bus answers
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response late");
  a_unmapped_read: assert property (s_rd_taken ##0 !(s_axi_araddr inside {32'h0, 32'h4, 32'h8})
    |=> s_axi_rresp == `SSF_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule // ssf_status_asserts
bind ssf_serial_status_flags ssf_status_asserts i_ssf_status_asserts (.*);

// ===== bench/ssf_serial_status_flags_bench.sv
`timescale 1ns/1ps
`include "ssf_defs.svh"
module ssf_serial_status_flags_bench;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] d;
    logic par;
    logic stop;
    logic mp;
    logic [7:0] st;
    logic [7:0] buf_v;
  } ssf_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic standby = 1'b0, tx_load = 1'b0, dma_tx_write = 1'b0, dma_rx_read = 1'b0;
  logic rx_done, rx_parity_bit, rx_stop_bit, rx_mp_bit, tx_last_bit;
  logic [7:0] rx_data, serial_status, serial_control, rx_buffer;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_multiproc_bit, rx_hold, tx_hold;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_v;
  int n_fail = 0;
  int compares = 0;
  // ordinary receptions, each from reset: control, char, parity, stop, mp -> status, buffer
  ssf_row_t rows [10] = '{
    '{8'h03, 8'hA5, 1'b0, 1'b1, 1'b0, 8'hC4, 8'hA5},
    '{8'h03, 8'hA5, 1'b0, 1'b0, 1'b0, 8'h94, 8'hA5},
    '{8'h0B, 8'h01, 1'b1, 1'b1, 1'b0, 8'hC4, 8'h01},
    '{8'h0B, 8'h01, 1'b0, 1'b1, 1'b0, 8'h8C, 8'h01},
    '{8'h1B, 8'h01, 1'b0, 1'b1, 1'b0, 8'hC4, 8'h01},
    '{8'h1B, 8'h01, 1'b1, 1'b1, 1'b0, 8'h8C, 8'h01},
    '{8'h23, 8'h3C, 1'b0, 1'b1, 1'b0, 8'hC4, 8'h3C},
    '{8'h07, 8'h3C, 1'b0, 1'b0, 1'b0, 8'hC4, 8'h3C},
    '{8'h01, 8'h3C, 1'b0, 1'b1, 1'b0, 8'h84, 8'h00},
    '{8'h43, 8'h3C, 1'b0, 1'b1, 1'b1, 8'hC6, 8'h3C}
  };
  ////////////////////////////////////////
  // 100 MHz clock, design and remote end
  always #5 aclk = ~aclk;
  ssf_serial_status_flags i_ssf_serial_status_flags (.*);
  ssf_remote_end i_ssf_remote_end (.*);
  ////////////////////////////////////////
  // checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // a wait that ran out counts as a mismatch and ends the run
  task automatic hang();
    chk(32'h0, 32'h1);
    end_sim();
  endtask
  // bus master: an edge passes first so no strobe is driven twice in one step
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) hang();
  endtask
  task automatic rd(input logic [31:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) hang();
  endtask
  // one-cycle event: standby, load, dma write, dma read; returns once the flag has landed
  task automatic ev(input logic [3:0] e);
    {standby, tx_load, dma_tx_write, dma_rx_read} <= e;
    @(posedge aclk);
    {standby, tx_load, dma_tx_write, dma_rx_read} <= 4'h0;
    @(posedge aclk);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    foreach (rows[i]) begin
      do_reset();
      wr(`SSF_ADDR_CTRL, rows[i].ctl);
      i_ssf_remote_end.send(rows[i].d, rows[i].par, rows[i].stop, rows[i].mp);
      chk(serial_status, rows[i].st);
      chk(rx_buffer, rows[i].buf_v);
    end
    $display("table done");
    // software access to the flags
    do_reset();
    wr(`SSF_ADDR_STATUS, 8'h00);
    chk(serial_status, 8'h84);
    rd(32'h0000_0010);
    chk(rsp, `SSF_RESP_SLVERR);
    wr(32'h0000_0010, 8'h00);
    chk(rsp, `SSF_RESP_SLVERR);
    rd(`SSF_ADDR_STATUS);
    chk(rd_v, 32'h84);
    wr(`SSF_ADDR_STATUS, 8'hFF);
    chk(serial_status & 8'hFE, 8'h84);
    wr(`SSF_ADDR_STATUS, 8'h07);
    chk(serial_status & 8'hFB, 8'h01);
    chk(tx_multiproc_bit, 1'b1);
    wr(`SSF_ADDR_CTRL, 8'hFF);
    chk(serial_control, 8'h7F);
    $display("register test done");
    // transmit side
    do_reset();
    wr(`SSF_ADDR_CTRL, 8'h03);
    ev(4'h2);
    chk(serial_status, 8'h00);
    i_ssf_remote_end.last_bit();
    chk(serial_status, 8'h00);
    ev(4'h4);
    chk(serial_status, 8'h80);
    i_ssf_remote_end.last_bit();
    chk(serial_status, 8'h84);
    ev(4'h2);
    wr(`SSF_ADDR_CTRL, 8'h02);
    @(posedge aclk);
    chk(serial_status, 8'h84);
    $display("transmit test done");
    // overrun in sync mode, then disable, dma read and software clear
    do_reset();
    wr(`SSF_ADDR_CTRL, 8'h07);
    i_ssf_remote_end.send(8'hA5, 1'b0, 1'b1, 1'b0);
    i_ssf_remote_end.send(8'h3C, 1'b1, 1'b0, 1'b1);
    @(posedge aclk);
    chk(serial_status, 8'hE4);
    chk({rx_hold, tx_hold}, 2'h3);
    i_ssf_remote_end.send(8'h5A, 1'b0, 1'b1, 1'b0);
    chk(rx_buffer, 8'hA5);
    rd(`SSF_ADDR_RXBUF);
    chk(rd_v, 32'hA5);
    wr(`SSF_ADDR_CTRL, 8'h05);
    chk(serial_status, 8'hE4);
    ev(4'h1);
    chk(serial_status, 8'hA4);
    rd(`SSF_ADDR_STATUS);
    wr(`SSF_ADDR_STATUS, 8'h80);
    chk(serial_status, 8'h84);
    $display("overrun test done");
    // standby in the middle of an error
    wr(`SSF_ADDR_CTRL, 8'h03);
    i_ssf_remote_end.send(8'h11, 1'b0, 1'b1, 1'b0);
    i_ssf_remote_end.send(8'h22, 1'b0, 1'b1, 1'b0);
    chk({rx_hold, tx_hold}, 2'h2);
    ev(4'h8);
    chk(serial_status, 8'h84);
    chk({rx_hold, tx_hold}, 2'h0);
    $display("standby test done");
    end_sim();
  end
endmodule // ssf_serial_status_flags_bench
